//--- verilog/adc_mode_pkg.sv
// Purpose: shared constants and types for the converter mode controller
// Assumes: master clock equals ref_clk at 125 MHz
// Notes:   command codes are 7-bit prefixes, so each pair of byte codes maps to one
package adc_mode_pkg;
   // timing, in printed units, and derived clock counts
   localparam int CLK_PERIOD_NS = 8;
   localparam int POR_TIME_NS = 2200000;
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_RESET_MIN_CLKS = 4;
   localparam int CMD_LATENCY_CLKS = 2;
   localparam int MOD_PERIOD_CLKS = 16;
   localparam int RST_CMD_CYCLES = 512;
   localparam int OSC_START_CYCLES = 64;
   localparam int CONV_MOD_PERIODS = 256;

   // register offsets
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_GAIN = 8'h03;
   localparam logic [7:0] ADDR_RATE = 8'h04;
   localparam logic [7:0] ADDR_REF = 8'h05;
   localparam logic [7:0] ADDR_CFG_LAST = 8'h07;

   // field positions
   localparam int STATUS_POR_BIT = 7;
   localparam int STATUS_NRDY_BIT = 6;
   localparam int GAIN_DELAY_LSB = 5;
   localparam int GAIN_AMP_LSB = 3;
   localparam int RATE_CLKSEL_BIT = 6;
   localparam int RATE_MODE_BIT = 5;
   localparam int RATE_LOWLAT_BIT = 4;
   localparam int REF_CTRL_LSB = 0;

   // reset values
   localparam logic [7:0] GAIN_RESET = 8'h08;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [7:0] REF_RESET = 8'h01;
   localparam logic [7:0] AUX_RESET = 8'h00;

   // field codes
   localparam logic [1:0] FIELD_OFF = 2'h0;
   localparam logic [1:0] REF_KEEP_IN_SLEEP = 2'h2;

   // command prefixes (upper seven bits of the command byte)
   localparam logic [6:0] CMD_RESUME = 7'h01;
   localparam logic [6:0] CMD_SLEEP = 7'h02;
   localparam logic [6:0] CMD_RESET = 7'h03;
   localparam logic [6:0] CMD_START = 7'h04;
   localparam logic [6:0] CMD_STOP = 7'h05;
   localparam logic [6:0] CMD_CAL = 7'h09;

   typedef enum logic [2:0] {
      ST_POR = 3'h0,
      ST_STANDBY = 3'h1,
      ST_DELAY = 3'h2,
      ST_CONVERT = 3'h3,
      ST_SLEEP = 3'h4,
      ST_WAKING = 3'h5,
      ST_RSTWAIT = 3'h6
   } state_type;

   // start delay code to modulator periods
   function automatic logic [12:0] delay_mods(input logic [2:0] code);
      case (code)
         3'h0: delay_mods = 13'h000E;
         3'h1: delay_mods = 13'h0001;
         3'h2: delay_mods = 13'h0002;
         3'h3: delay_mods = 13'h0004;
         3'h4: delay_mods = 13'h0010;
         3'h5: delay_mods = 13'h0040;
         3'h6: delay_mods = 13'h0100;
         default: delay_mods = 13'h1000;
      endcase
   endfunction : delay_mods
endpackage : adc_mode_pkg

//--- verilog/adc_mode_ctrl.sv
// Purpose: operating mode sequencer of a delta-sigma converter
// Assumes: serial pins and reset pin are asynchronous to ref_clk
// Notes:   register port stands for the serial register access path
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

module adc_mode_ctrl #(
   parameter int POR_CLKS = adc_mode_pkg::POR_CYCLES,
   parameter int RST_CMD_CLKS = adc_mode_pkg::RST_CMD_CYCLES,
   parameter int OSC_START_CLKS = adc_mode_pkg::OSC_START_CYCLES,
   parameter int CONV_MODS = adc_mode_pkg::CONV_MOD_PERIODS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // device pins
   input wire logic reset_pin_n,
   input wire logic trigger_pin,
   input wire logic sclk_pin,
   input wire logic din_pin,
   input wire logic cs_pin_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // converter controls
   output logic result_ready_output_n,
   output logic amp_power_on,
   output logic ref_power_on,
   output logic excitation_on,
   output logic filter_reset,
   output logic mod_clk_en,
   output logic internal_osc_sel,
   output logic cal_start,
   output logic sleep_active
);
   import adc_mode_pkg::*;

   state_type state_reg;
   logic [19:0] cnt_reg;
   logic [3:0] mod_div_reg;
   logic mod_tick;
   logic [12:0] dly_reg;
   logic [15:0] conv_reg;
   logic [1:0] shots_reg;
   logic stop_pend_reg;
   logic deliver_reg;
   logic power_on_occurred_flag;
   logic not_ready_reg;
   logic [7:0] cfg_reg [3:7];
   logic [2:0] trig_sync_reg, sclk_sync_reg;
   logic [1:0] rst_sync_reg, din_sync_reg, cs_sync_reg;
   logic [2:0] low_cnt_reg;
   logic pin_reset_reg;
   logic [6:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic [6:0] cmd_reg;
   logic cmd_valid_reg;
   logic [1:0] start_pipe_reg, stop_pipe_reg, sleep_pipe_reg, trig_pipe_reg;
   logic sclk_fall, sclk_rise, trig_rise, trig_fall;
   logic asleep, running, cmd_open, reset_cmd, cfg_write, wr_ok;
   logic start_go, stop_go, sleep_go, trig_go, single_mode;

   // pin synchronisers: stage 0 is read only by stage 1
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rst_sync_reg <= 2'h3;
         trig_sync_reg <= 3'h0;
         sclk_sync_reg <= 3'h0;
         din_sync_reg <= 2'h0;
         cs_sync_reg <= 2'h3;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], reset_pin_n};
         trig_sync_reg <= {trig_sync_reg[1:0], trigger_pin};
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
         din_sync_reg <= {din_sync_reg[0], din_pin};
         cs_sync_reg <= {cs_sync_reg[0], cs_pin_n};
      end
   end

   assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
   assign sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
   assign trig_rise = ~trig_sync_reg[2] & trig_sync_reg[1];
   assign trig_fall = trig_sync_reg[2] & ~trig_sync_reg[1];
   assign asleep = (state_reg == ST_SLEEP) || (state_reg == ST_WAKING);
   assign running = (state_reg == ST_DELAY) || (state_reg == ST_CONVERT);
   assign single_mode = cfg_reg[ADDR_RATE][RATE_MODE_BIT];
   // commands are refused while the part settles after any reset
   assign cmd_open = (state_reg != ST_POR) && (state_reg != ST_RSTWAIT);

   // pin reset width
   // a pulse shorter than four clocks is treated as a glitch
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         low_cnt_reg <= 3'h0;
         pin_reset_reg <= 1'b0;
      end else begin
         pin_reset_reg <= 1'b0;
         if (!rst_sync_reg[1]) begin
            if (low_cnt_reg != 3'(PIN_RESET_MIN_CLKS))
               low_cnt_reg <= low_cnt_reg + 3'h1;
         end else begin
            if (low_cnt_reg == 3'(PIN_RESET_MIN_CLKS))
               pin_reset_reg <= 1'b1;
            low_cnt_reg <= 3'h0;
         end
      end
   end

   // decode on seventh edge
   // bits are taken on falling serial edges; chip select high clears the framing
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         shift_reg <= 7'h00;
         bit_cnt_reg <= 3'h0;
         cmd_reg <= 7'h00;
         cmd_valid_reg <= 1'b0;
      end else begin
         cmd_valid_reg <= 1'b0;
         if (cs_sync_reg[1]) begin
            bit_cnt_reg <= 3'h0;
         end else if (sclk_fall) begin
            shift_reg <= {shift_reg[5:0], din_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;   // eighth edge wraps to zero
            if (bit_cnt_reg == 3'h6) begin
               cmd_reg <= {shift_reg[5:0], din_sync_reg[1]};
               cmd_valid_reg <= cmd_open;
            end
         end
      end
   end

   assign reset_cmd = cmd_valid_reg && (cmd_reg == CMD_RESET) && !asleep;

   // two-clock latency
   // start, stop, sleep and rising trigger edges each ride a two-stage delay line
   always_ff @(posedge ref_clk) begin
      if (srst || pin_reset_reg || reset_cmd) begin
         start_pipe_reg <= 2'h0;
         stop_pipe_reg <= 2'h0;
         sleep_pipe_reg <= 2'h0;
         trig_pipe_reg <= 2'h0;
      end else begin
         start_pipe_reg <= {start_pipe_reg[0],
                            cmd_valid_reg && cmd_reg == CMD_START && !asleep};
         stop_pipe_reg <= {stop_pipe_reg[0],
                           cmd_valid_reg && cmd_reg == CMD_STOP && !asleep};
         sleep_pipe_reg <= {sleep_pipe_reg[0],
                            cmd_valid_reg && cmd_reg == CMD_SLEEP && !asleep};
         trig_pipe_reg <= {trig_pipe_reg[0], trig_rise && cmd_open && !asleep};
      end
   end

   assign start_go = start_pipe_reg[CMD_LATENCY_CLKS-1];
   assign stop_go = stop_pipe_reg[CMD_LATENCY_CLKS-1];
   assign sleep_go = sleep_pipe_reg[CMD_LATENCY_CLKS-1];
   assign trig_go = trig_pipe_reg[CMD_LATENCY_CLKS-1];

   // modulator clock gate
   // the divider only runs in the delay and convert states, so standby sees no ticks
   always_ff @(posedge ref_clk) begin
      if (srst || !running || start_go || trig_go || cfg_write)
         mod_div_reg <= 4'h0;
      else
         mod_div_reg <= mod_div_reg + 4'h1;
   end

   assign mod_tick = running && (mod_div_reg == 4'(MOD_PERIOD_CLKS - 1));

   // write gate
   // writes are dropped in sleep, while the oscillator restarts and before ready
   assign wr_ok = reg_wr && !asleep && cmd_open;
   assign cfg_write = wr_ok && (reg_addr >= ADDR_GAIN) && (reg_addr <= ADDR_CFG_LAST);

   always_ff @(posedge ref_clk) begin
      if (srst || pin_reset_reg || reset_cmd) begin
         cfg_reg[3] <= GAIN_RESET;
         cfg_reg[4] <= RATE_RESET;
         cfg_reg[5] <= REF_RESET;
         cfg_reg[6] <= AUX_RESET;
         cfg_reg[7] <= AUX_RESET;
      end else if (cfg_write) begin
         cfg_reg[reg_addr[2:0]] <= reg_wdata;
      end
   end

   // status flags; a hardware set beats a same-cycle software clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         power_on_occurred_flag <= 1'b0;
         not_ready_reg <= 1'b1;
      end else begin
         if (wr_ok && reg_addr == ADDR_STATUS && !reg_wdata[STATUS_POR_BIT])
            power_on_occurred_flag <= 1'b0;
         if (state_reg == ST_POR && cnt_reg == 20'(POR_CLKS - 1)) begin
            power_on_occurred_flag <= 1'b1;
            not_ready_reg <= 1'b0;
         end
      end
   end

   // register read, data one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == ADDR_STATUS)
            reg_rdata <= {power_on_occurred_flag, not_ready_reg, 3'h0, state_reg};
         else if (reg_addr >= ADDR_GAIN && reg_addr <= ADDR_CFG_LAST)
            reg_rdata <= cfg_reg[reg_addr[2:0]];
         else
            reg_rdata <= 8'h00;
      end
   end

   // mode sequencer
   always_ff @(posedge ref_clk) begin
      deliver_reg <= 1'b0;
      if (srst) begin
         state_reg <= ST_POR;
         cnt_reg <= 20'h00000;
         dly_reg <= 13'h0000;
         conv_reg <= 16'h0000;
         shots_reg <= 2'h0;
         stop_pend_reg <= 1'b0;
         deliver_reg <= 1'b0;
      end else if ((pin_reset_reg && state_reg != ST_POR) || reset_cmd) begin
         state_reg <= ST_RSTWAIT;
         cnt_reg <= 20'h00000;
         stop_pend_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_POR: begin
               cnt_reg <= cnt_reg + 20'h00001;
               if (cnt_reg == 20'(POR_CLKS - 1))
                  state_reg <= ST_STANDBY;
            end
            ST_RSTWAIT: begin
               cnt_reg <= cnt_reg + 20'h00001;
               if (cnt_reg == 20'(RST_CMD_CLKS - 1))
                  state_reg <= ST_STANDBY;
            end
            ST_STANDBY: begin
               if (sleep_go) begin
                  state_reg <= ST_SLEEP;
               end else if (start_go || trig_go) begin
                  state_reg <= ST_DELAY;
                  dly_reg <= delay_mods(cfg_reg[ADDR_GAIN][GAIN_DELAY_LSB +: 3]);
                  shots_reg <= cfg_reg[ADDR_RATE][RATE_LOWLAT_BIT] ? 2'h1 : 2'h3;
                  stop_pend_reg <= 1'b0;
               end
            end
            ST_DELAY, ST_CONVERT: begin
               if (sleep_go) begin
                  state_reg <= ST_SLEEP;
               end else if (start_go || trig_go || cfg_write) begin
                  state_reg <= ST_DELAY;
                  dly_reg <= delay_mods(cfg_write ?
                     reg_wdata[GAIN_DELAY_LSB +: 3] :
                     cfg_reg[ADDR_GAIN][GAIN_DELAY_LSB +: 3]);
                  if (cfg_write && reg_addr != ADDR_GAIN)
                     dly_reg <= delay_mods(cfg_reg[ADDR_GAIN][GAIN_DELAY_LSB +: 3]);
                  shots_reg <= cfg_reg[ADDR_RATE][RATE_LOWLAT_BIT] ? 2'h1 : 2'h3;
                  stop_pend_reg <= 1'b0;
               end else if (state_reg == ST_DELAY) begin
                  if (stop_go || (!single_mode && trig_fall))
                     stop_pend_reg <= 1'b1;
                  if (mod_tick) begin
                     dly_reg <= dly_reg - 13'h0001;
                     if (dly_reg == 13'h0001) begin
                        state_reg <= ST_CONVERT;
                        conv_reg <= 16'h0000;
                     end
                  end
               end else begin
                  if (stop_go || (!single_mode && trig_fall))
                     stop_pend_reg <= 1'b1;
                  if (mod_tick) begin
                     conv_reg <= conv_reg + 16'h0001;
                     if (conv_reg == 16'(CONV_MODS - 1)) begin
                        conv_reg <= 16'h0000;
                        if (single_mode) begin
                           shots_reg <= shots_reg - 2'h1;
                           if (shots_reg == 2'h1) begin
                              deliver_reg <= 1'b1;
                              state_reg <= ST_STANDBY;
                           end
                        end else begin
                           deliver_reg <= 1'b1;
                           if (stop_pend_reg || stop_go)
                              state_reg <= ST_STANDBY;
                        end
                     end
                  end
               end
            end
            ST_SLEEP: begin
               if (cmd_valid_reg && cmd_reg == CMD_RESUME) begin
                  state_reg <= ST_WAKING;
                  cnt_reg <= 20'h00000;
               end
            end
            ST_WAKING: begin
               cnt_reg <= cnt_reg + 20'h00001;
               if (cnt_reg == 20'(OSC_START_CLKS - 1))
                  state_reg <= ST_STANDBY;
            end
            default: state_reg <= ST_POR;
         endcase
      end
   end

   // ready output handling
   // a fresh result wins over a same-cycle clearing edge
   always_ff @(posedge ref_clk) begin
      if (srst || pin_reset_reg || reset_cmd)
         result_ready_output_n <= 1'b1;
      else if (deliver_reg)
         result_ready_output_n <= 1'b0;
      else if (sclk_rise || trig_rise)
         result_ready_output_n <= 1'b1;
   end

   // analog, clock and core controls, registered from state, fields and the command strobe
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         amp_power_on <= 1'b0;
         ref_power_on <= 1'b0;
         excitation_on <= 1'b0;
         filter_reset <= 1'b1;
         mod_clk_en <= 1'b0;
         internal_osc_sel <= 1'b1;
         cal_start <= 1'b0;
         sleep_active <= 1'b0;
      end else begin
         amp_power_on <= running ||
            (state_reg == ST_STANDBY && cfg_reg[ADDR_GAIN][GAIN_AMP_LSB +: 2] != FIELD_OFF);
         excitation_on <= !asleep && cfg_reg[ADDR_REF][REF_CTRL_LSB +: 2] != FIELD_OFF;
         ref_power_on <= asleep ?
            cfg_reg[ADDR_REF][REF_CTRL_LSB +: 2] == REF_KEEP_IN_SLEEP :
            cfg_reg[ADDR_REF][REF_CTRL_LSB +: 2] != FIELD_OFF;
         filter_reset <= state_reg != ST_CONVERT;
         mod_clk_en <= running;
         internal_osc_sel <= !cfg_reg[ADDR_RATE][RATE_CLKSEL_BIT];
         cal_start <= cmd_valid_reg && cmd_reg == CMD_CAL && running;
         sleep_active <= asleep;
      end
   end
endmodule : adc_mode_ctrl

//--- tb/adc_mode_sva.sv
// Purpose: port checks for the mode controller
// Assumes: single ref_clk domain, srst synchronous
// Notes:   bound to every controller instance
`timescale 1ns/1ps
module adc_mode_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // pins
   input wire logic reset_pin_n,
   input wire logic trigger_pin,
   input wire logic sclk_pin,
   // controls
   input wire logic result_ready_output_n,
   input wire logic amp_power_on,
   input wire logic excitation_on,
   input wire logic filter_reset,
   input wire logic mod_clk_en,
   input wire logic internal_osc_sel,
   input wire logic cal_start,
   input wire logic sleep_active
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // pin low at least four clocks, then released
   sequence pin_pulse;
      !reset_pin_n [*4] ##1 reset_pin_n;
   endsequence
   // outputs that any reset leaves behind
   sequence idle_outs;
      result_ready_output_n && filter_reset && internal_osc_sel;
   endsequence
   a_reset_outs_idle: assert property (
      $fell(srst) |-> idle_outs ##0 (!mod_clk_en && !sleep_active && !cal_start))
      else $error("outputs not idle after reset");
   a_pin_reset_idle: assert property (
      pin_pulse |-> ##[1:8] idle_outs) else $error("pin reset not seen");
   a_sleep_gated: assert property (
      sleep_active && $past(sleep_active) |-> !amp_power_on && !excitation_on && !mod_clk_en)
      else $error("circuits powered in sleep");
   a_sleep_no_ready: assert property (
      sleep_active |-> !$fell(result_ready_output_n)) else $error("result while asleep");
   a_cal_running: assert property (
      cal_start |-> mod_clk_en) else $error("calibration in standby");
   a_cal_one_pulse: assert property (
      cal_start |=> !cal_start) else $error("calibration pulse too long");
   a_filter_needs_clk: assert property (
      $fell(filter_reset) |-> ##[0:2] mod_clk_en) else $error("filter runs unclocked");
   a_ready_on_sclk: assert property (
      $rose(sclk_pin) |-> ##[1:6] result_ready_output_n) else $error("ready not raised by sclk");
   a_ready_on_trig: assert property (
      $rose(trigger_pin) |-> ##[1:8] result_ready_output_n) else $error("ready not raised by pin");
   a_trig_starts: assert property (
      $rose(trigger_pin) && filter_reset && !sleep_active |-> ##[2:10] mod_clk_en)
      else $error("trigger did not start");
endmodule : adc_mode_sva

bind adc_mode_ctrl adc_mode_sva u_sva (
   .ref_clk(ref_clk), .srst(srst), .reset_pin_n(reset_pin_n),
   .trigger_pin(trigger_pin), .sclk_pin(sclk_pin),
   .result_ready_output_n(result_ready_output_n), .amp_power_on(amp_power_on),
   .excitation_on(excitation_on), .filter_reset(filter_reset), .mod_clk_en(mod_clk_en),
   .internal_osc_sel(internal_osc_sel), .cal_start(cal_start), .sleep_active(sleep_active)
);

//--- tb/adc_host_model.sv
// Purpose: serial host that sends command bytes
// Assumes: link clock period 64 ns, idle low
// Notes:   data line shows no stale value outside frames
`timescale 1ns/1ps
module adc_host_model (
   // serial pins
   output logic sclk_pin,
   output logic din_pin,
   output logic cs_pin_n
);
   // idle frame state at time zero
   initial begin
      sclk_pin = 1'b0;
      din_pin = 1'b0;
      cs_pin_n = 1'b1;
   end
   // msb first, taken on falling edges
   task automatic send_byte(input logic [7:0] b);
      #3 cs_pin_n = 1'b0; // offset keeps edges off ref_clk
      for (int i = 7; i >= 0; i--) begin
         #32 sclk_pin = 1'b1;
         din_pin = b[i];
         #32 sclk_pin = 1'b0;
      end
      #32 cs_pin_n = 1'b1;
      din_pin = ~din_pin; // released line must not look held
      #64;
   endtask : send_byte
endmodule : adc_host_model

//--- tb/adc_operating_mode_control_tb_top.sv
// Purpose: self-checking bench of the mode controller
// Assumes: shortened power-on, reset wait and conversion counts
// Notes:   delay timing compared as differences between runs
`timescale 1ns/1ps
module adc_operating_mode_control_tb_top;
   import adc_mode_pkg::*;
   localparam int POR_N = 20;
   localparam int RST_N = 8;
   localparam int CONV_N = 4;
   logic ref_clk, srst, reset_pin_n, trigger_pin;
   logic sclk_pin, din_pin, cs_pin_n;
   logic [7:0] reg_addr, reg_wdata;
   logic reg_wr, reg_rd;
   logic [7:0] reg_rdata, cal_n;
   logic result_ready_output_n, amp_power_on, ref_power_on, excitation_on;
   logic filter_reset, mod_clk_en, internal_osc_sel, cal_start, sleep_active;
   int n_fail = 0;
   int cmp_count = 0;
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   adc_host_model u_host (.sclk_pin(sclk_pin), .din_pin(din_pin), .cs_pin_n(cs_pin_n));
   adc_mode_ctrl #(.POR_CLKS(POR_N), .RST_CMD_CLKS(RST_N), .OSC_START_CLKS(4),
      .CONV_MODS(CONV_N)) uut (
      .ref_clk(ref_clk), .srst(srst), .reset_pin_n(reset_pin_n),
      .trigger_pin(trigger_pin), .sclk_pin(sclk_pin), .din_pin(din_pin),
      .cs_pin_n(cs_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_ready_output_n(result_ready_output_n),
      .amp_power_on(amp_power_on), .ref_power_on(ref_power_on),
      .excitation_on(excitation_on), .filter_reset(filter_reset), .mod_clk_en(mod_clk_en),
      .internal_osc_sel(internal_osc_sel), .cal_start(cal_start),
      .sleep_active(sleep_active));
   // count accepted calibration pulses
   always_ff @(posedge ref_clk) begin
      cal_n <= srst ? 8'h00 : cal_n + {7'h00, cal_start};
   end
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check($sformatf("reg %h", a), exp, reg_rdata);
   endtask : rd
   function automatic logic pick(input int s);
      case (s)
         0: pick = mod_clk_en;
         1: pick = result_ready_output_n;
         default: pick = sleep_active;
      endcase
   endfunction : pick
   // bounded wait for an output level, cycles counted in n
   task automatic wait_on(input int s, input logic lvl, output int n);
      n = 0;
      while (pick(s) !== lvl && n < 6000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 6000) begin
         n_fail++;
         test_done();
      end
   endtask : wait_on
   // one single-shot run; n is start-to-result cycles
   task automatic shot(input logic [2:0] code, input logic [7:0] rate, output int n);
      int t;
      wr(ADDR_GAIN, {code, 5'h08});
      wr(ADDR_RATE, rate);
      u_host.send_byte(8'h08);
      wait_on(1, 1'b0, n);
      wait_on(0, 1'b0, t);
   endtask : shot
   // main sequence
   initial begin
      int n1, n0, n4, n3, t;
      srst <= 1'b1;
      reset_pin_n <= 1'b1;
      // pin held low while commands control
      trigger_pin <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      rd(ADDR_STATUS, 8'h40);
      repeat (POR_N + 4) @(posedge ref_clk);
      rd(ADDR_STATUS, 8'h81);
      rd(ADDR_GAIN, GAIN_RESET);
      rd(ADDR_RATE, RATE_RESET);
      rd(ADDR_REF, REF_RESET);
      rd(8'h02, 8'h00);
      wr(ADDR_GAIN, 8'h00);
      wr(ADDR_REF, 8'h00);
      repeat (3) @(posedge ref_clk);
      check("standby outs", 8'h02, {3'h0, amp_power_on, ref_power_on, excitation_on,
         filter_reset, mod_clk_en});
      shot(3'h1, 8'h30, n1);
      shot(3'h0, 8'h30, n0);
      shot(3'h4, 8'h30, n4);
      check("delay 14", 8'((14 - 1) * MOD_PERIOD_CLKS), 8'(n0 - n1));
      check("delay 16", 8'((16 - 1) * MOD_PERIOD_CLKS), 8'(n4 - n1));
      shot(3'h1, 8'h20, n3);
      check("sinc3 shot", 8'(2 * CONV_N * MOD_PERIOD_CLKS), 8'(n3 - n1));
      wr(ADDR_RATE, 8'h00);
      trigger_pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      wait_on(1, 1'b0, t);
      trigger_pin <= 1'b0;
      wait_on(0, 1'b0, t);
      check("finish on pin low", 8'h01, {7'h00, t > 40 && t < 80});
      wr(ADDR_REF, {6'h00, REF_KEEP_IN_SLEEP});
      u_host.send_byte(8'h0A);
      u_host.send_byte(8'h08);
      u_host.send_byte(8'h04);
      wait_on(2, 1'b1, t);
      check("sleep outs", 8'h14, {3'h0, internal_osc_sel, amp_power_on, ref_power_on,
         excitation_on, mod_clk_en});
      wr(ADDR_GAIN, 8'hE0);
      u_host.send_byte(8'h06);
      rd(ADDR_GAIN, 8'h28);
      rd(ADDR_STATUS, 8'h84);
      u_host.send_byte(8'h02);
      wait_on(2, 1'b0, t);
      rd(ADDR_STATUS, 8'h81);
      u_host.send_byte(8'h12);
      check("cal in standby", 8'h00, cal_n);
      u_host.send_byte(8'h08);
      u_host.send_byte(8'h12);
      check("cal running", 8'h01, cal_n);
      u_host.send_byte(8'h0A);
      wait_on(0, 1'b0, t);
      u_host.send_byte(8'h06);
      repeat (RST_N + 4) @(posedge ref_clk);
      rd(ADDR_REF, REF_RESET);
      rd(ADDR_STATUS, 8'h81);
      wr(ADDR_RATE, 8'h70);
      reset_pin_n <= 1'b0;
      repeat (PIN_RESET_MIN_CLKS + 2) @(posedge ref_clk);
      check("ext clock", 8'h00, {7'h00, internal_osc_sel});
      reset_pin_n <= 1'b1;
      repeat (RST_N + 6) @(posedge ref_clk);
      rd(ADDR_RATE, RATE_RESET);
      check("osc after reset", 8'h01, {7'h00, internal_osc_sel});
      test_done();
   end
endmodule : adc_operating_mode_control_tb_top
